//--- verilog/usbm_pkg.sv
// package: register map, field positions and timing of the usb mask/suspend block
package usbm_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int BUS_RESET_MASK_BIT = 10;
  localparam int FRAME_START_MASK_BIT = 9;
  localparam int EXP_FRAME_MASK_BIT = 8;
  localparam int SLEEP_REQ_MASK_BIT = 7;
  localparam int SLEEP_WAKEUP_BIT = 5;
  localparam int RESUME_BIT = 4;
  localparam int FORCE_SUSPEND_BIT = 3;
  localparam int LOW_POWER_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ----------------------------------------
  // status register fields
  // ----------------------------------------
  localparam int ST_SUSPENDED_BIT = 0;
  localparam int ST_RESUMING_BIT = 1;
  localparam int ST_SLEEP_WAKE_BIT = 2;
  localparam int ST_LOW_POWER_BIT = 3;
  // ----------------------------------------
  // block interrupt status fields
  // ----------------------------------------
  localparam int IRQ_SUSPEND_BIT = 0;
  localparam int IRQ_RESUME_DONE_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int IDLE_SUSPEND_US = 3000;
  localparam int IDLE_SUSPEND_CYCLES = IDLE_SUSPEND_US * CLK_MHZ;
  localparam int SLEEP_WAKE_US = 50;
  localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_US * CLK_MHZ;
endpackage

//--- verilog/usbm_ctrl.sv
// usb device interrupt masks, resume signalling and suspend control
// Contract
// [RQ1] bus reset flag raises irq only while its mask bit 10 is set
// [RQ2] frame start flag raises irq only while its mask bit 9 is set
// [RQ3] expected frame start flag raises irq only while mask bit 8 set
// [RQ4] sleep request flag raises irq only while mask bit 7 is set
// [RQ5] bit 5 drives sleep wakeup signalling; hardware clears it when done
// [RQ6] while bit 4 set, resume signalling is driven toward the host
// [RQ7] software holds bit 4 between 1 ms and 15 ms
// [RQ8] suspend flag raised after 3 ms without bus traffic
// [RQ9] software sets force suspend on the suspend interrupt
// [RQ10] writing 1 to bit 3 enters suspend; writing 0 does nothing
// [RQ11] software sets low power after force suspend when current matters
// [RQ12] irq output high while any flag and its mask are both set
//
// Our own choices: the placing of the registers and the APB slave port.
module usbm_ctrl #(
  parameter int IDLE_CYCLES = usbm_pkg::IDLE_SUSPEND_CYCLES,
  parameter int WAKE_CYCLES = usbm_pkg::SLEEP_WAKE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_reset_event,
  input wire logic frame_start_event,
  input wire logic expected_frame_start_event,
  input wire logic sleep_request_event,
  input wire logic bus_activity,
  input wire logic bus_resume_seen,
  output logic usb_irq,
  output logic block_irq,
  output logic suspend_event,
  output logic resume_drive,
  output logic sleep_wakeup_drive,
  output logic suspended,
  output logic low_power
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic ctrl_sel;
  logic status_sel;
  logic stat_sel;
  logic mask_sel;
  logic addr_ok;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign ctrl_sel = paddr == usbm_pkg::CTRL_OFF;
  assign status_sel = paddr == usbm_pkg::STATUS_OFF;
  assign stat_sel = paddr == usbm_pkg::IRQ_STAT_OFF;
  assign mask_sel = paddr == usbm_pkg::IRQ_MASK_OFF;
  assign addr_ok = ctrl_sel || status_sel || stat_sel || mask_sel;

  // ----------------------------------------
  // bus response
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ----------------------------------------
  // activity synchroniser
  // ----------------------------------------
  logic act_s1;
  logic act_s2;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end else begin
      act_s1 <= bus_activity;
      act_s2 <= act_s1;
    end
  end

  // ----------------------------------------
  // host resume synchroniser
  // ----------------------------------------
  logic res_s1;
  logic res_s2;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_s1 <= 1'b0;
      res_s2 <= 1'b0;
    end else begin
      res_s1 <= bus_resume_seen;
      res_s2 <= res_s1;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [31:0] ctrl;
  logic wake_done;
  logic ctrl_wr;
  assign ctrl_wr = wr_en && paddr == usbm_pkg::CTRL_OFF;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= usbm_pkg::CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl[usbm_pkg::BUS_RESET_MASK_BIT] <= pwdata[usbm_pkg::BUS_RESET_MASK_BIT];
        ctrl[usbm_pkg::FRAME_START_MASK_BIT] <= pwdata[usbm_pkg::FRAME_START_MASK_BIT];
        ctrl[usbm_pkg::EXP_FRAME_MASK_BIT] <= pwdata[usbm_pkg::EXP_FRAME_MASK_BIT];
        ctrl[usbm_pkg::SLEEP_REQ_MASK_BIT] <= pwdata[usbm_pkg::SLEEP_REQ_MASK_BIT];
        ctrl[usbm_pkg::RESUME_BIT] <= pwdata[usbm_pkg::RESUME_BIT];
        ctrl[usbm_pkg::LOW_POWER_BIT] <= pwdata[usbm_pkg::LOW_POWER_BIT];
      end
      // [RQ5] wakeup set or self clear
      if (ctrl_wr && pwdata[usbm_pkg::SLEEP_WAKEUP_BIT]) begin
        ctrl[usbm_pkg::SLEEP_WAKEUP_BIT] <= 1'b1;
      end else if (wake_done) begin
        ctrl[usbm_pkg::SLEEP_WAKEUP_BIT] <= 1'b0;
      end
      // [RQ10] write one enters suspend
      if (ctrl_wr && pwdata[usbm_pkg::FORCE_SUSPEND_BIT]) begin
        ctrl[usbm_pkg::FORCE_SUSPEND_BIT] <= 1'b1;
      end else if (res_s2 || ctrl[usbm_pkg::RESUME_BIT]) begin
        ctrl[usbm_pkg::FORCE_SUSPEND_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sleep wakeup timer
  // ----------------------------------------
  logic [31:0] wake_cnt;
  assign wake_done = ctrl[usbm_pkg::SLEEP_WAKEUP_BIT] && wake_cnt == 32'(WAKE_CYCLES - 1);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_cnt <= 32'h0000_0000;
    end else if (ctrl[usbm_pkg::SLEEP_WAKEUP_BIT] && !wake_done) begin
      wake_cnt <= wake_cnt + 32'h0000_0001;
    end else begin
      wake_cnt <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // idle detector
  // ----------------------------------------
  logic [31:0] idle_cnt;
  logic idle_hit;
  assign idle_hit = !act_s2 && idle_cnt == 32'(IDLE_CYCLES - 1);
  // [RQ8] three ms idle count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_cnt <= 32'h0000_0000;
    end else if (act_s2) begin
      idle_cnt <= 32'h0000_0000;
    end else if (idle_cnt != 32'(IDLE_CYCLES)) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // block interrupt status and mask
  // ----------------------------------------
  logic [usbm_pkg::IRQ_WIDTH-1:0] irq_stat;
  logic [usbm_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [usbm_pkg::IRQ_WIDTH-1:0] irq_set;
  logic stat_rd;
  logic resume_prev;
  assign stat_rd = rd_en && paddr == usbm_pkg::IRQ_STAT_OFF;
  // [RQ8] idle sets suspend flag
  assign irq_set[usbm_pkg::IRQ_SUSPEND_BIT] = idle_hit;
  logic resume_done;
  assign resume_done = resume_prev && !ctrl[usbm_pkg::RESUME_BIT];
  assign irq_set[usbm_pkg::IRQ_RESUME_DONE_BIT] = wake_done || resume_done;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resume_prev <= 1'b0;
    end else begin
      resume_prev <= ctrl[usbm_pkg::RESUME_BIT];
    end
  end
  // set wins over read clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (stat_rd ? '0 : irq_stat) | irq_set;
    end
  end

  // ----------------------------------------
  // block interrupt mask
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask <= usbm_pkg::IRQ_MASK_RESET;
    end else if (wr_en && paddr == usbm_pkg::IRQ_MASK_OFF) begin
      irq_mask <= pwdata[usbm_pkg::IRQ_WIDTH-1:0];
    end
  end
  assign block_irq = |(irq_stat & irq_mask);
  assign suspend_event = irq_stat[usbm_pkg::IRQ_SUSPEND_BIT];

  // ----------------------------------------
  // usb event interrupt gating
  // ----------------------------------------
  logic [3:0] ev_flags;
  logic [3:0] ev_masks;
  logic [3:0] ev_hits;
  assign ev_flags[3] = bus_reset_event;
  assign ev_flags[2] = frame_start_event;
  assign ev_flags[1] = expected_frame_start_event;
  assign ev_flags[0] = sleep_request_event;
  // [RQ1] bus reset mask
  assign ev_masks[3] = ctrl[usbm_pkg::BUS_RESET_MASK_BIT];
  // [RQ2] frame start mask
  assign ev_masks[2] = ctrl[usbm_pkg::FRAME_START_MASK_BIT];
  // [RQ3] expected frame mask
  assign ev_masks[1] = ctrl[usbm_pkg::EXP_FRAME_MASK_BIT];
  // [RQ4] sleep request mask
  assign ev_masks[0] = ctrl[usbm_pkg::SLEEP_REQ_MASK_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ev
      assign ev_hits[gi] = ev_flags[gi] && ev_masks[gi];
    end
  endgenerate
  // [RQ12] any flag with mask
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      usb_irq <= 1'b0;
    end else begin
      usb_irq <= |ev_hits;
    end
  end

  // ----------------------------------------
  // link signalling outputs
  // ----------------------------------------
  // [RQ6] resume while bit held
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resume_drive <= 1'b0;
    end else begin
      resume_drive <= ctrl[usbm_pkg::RESUME_BIT];
    end
  end

  // [RQ5] wakeup drive per bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_wakeup_drive <= 1'b0;
    end else begin
      sleep_wakeup_drive <= ctrl[usbm_pkg::SLEEP_WAKEUP_BIT];
    end
  end

  // [RQ10] suspend state output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      suspended <= 1'b0;
    end else begin
      suspended <= ctrl[usbm_pkg::FORCE_SUSPEND_BIT];
    end
  end

  // low power output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_power <= 1'b0;
    end else begin
      low_power <= ctrl[usbm_pkg::LOW_POWER_BIT];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[usbm_pkg::ST_SUSPENDED_BIT] = suspended;
    status_word[usbm_pkg::ST_RESUMING_BIT] = resume_drive;
    status_word[usbm_pkg::ST_SLEEP_WAKE_BIT] = sleep_wakeup_drive;
    status_word[usbm_pkg::ST_LOW_POWER_BIT] = low_power;
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        usbm_pkg::CTRL_OFF: prdata <= ctrl;
        usbm_pkg::STATUS_OFF: prdata <= status_word;
        usbm_pkg::IRQ_STAT_OFF: prdata <= {30'h0, irq_stat | irq_set};
        usbm_pkg::IRQ_MASK_OFF: prdata <= {30'h0, irq_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // usbm_ctrl

//--- dv/usbm_sva.sv
// checker: port properties of the usb mask and suspend block
module usbm_sva #(
  parameter int IDLE_CYCLES = 50,
  parameter int WAKE_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic bus_reset_event,
  input wire logic frame_start_event,
  input wire logic expected_frame_start_event,
  input wire logic sleep_request_event,
  input wire logic bus_activity,
  input wire logic usb_irq,
  input wire logic suspend_event,
  input wire logic resume_drive,
  input wire logic sleep_wakeup_drive,
  input wire logic suspended
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WMAX = WAKE_CYCLES + 3;
  localparam int ILO = IDLE_CYCLES - 1;
  localparam int IHI = IDLE_CYCLES + 5;
  logic wr;
  logic [3:0] msk;
  logic [3:0] ev;
  int idle;
  assign wr = psel && penable && pwrite && paddr == usbm_pkg::CTRL_OFF;
  assign ev = {bus_reset_event, frame_start_event, expected_frame_start_event,
    sleep_request_event};
  always_ff @(posedge ref_clk) begin
    if (rst) msk <= 4'h0;
    else if (wr) msk <= pwdata[10:7];
  end
  always_ff @(posedge ref_clk) begin
    if (rst || bus_activity) idle <= 0;
    else idle <= idle + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_bus_reset_irq: assert property ($past(ev[3] & msk[3]) |-> usb_irq)
    else $error("no irq on bus reset");
  a_frame_irq: assert property ($past(ev[2] & msk[2]) |-> usb_irq)
    else $error("no irq on frame start");
  a_exp_frame_irq: assert property ($past(ev[1] & msk[1]) |-> usb_irq)
    else $error("no irq on expected frame");
  a_sleep_req_irq: assert property ($past(ev[0] & msk[0]) |-> usb_irq)
    else $error("no irq on sleep request");
  a_irq_has_cause: assert property (usb_irq |-> $past(ev & msk) != 4'h0)
    else $error("irq without masked flag");
  a_wake_self_clear: assert property ((wr && pwdata[5]) |->
    ##2 sleep_wakeup_drive ##[1:WMAX] !sleep_wakeup_drive) else $error("wakeup not ended");
  a_resume_drive_on: assert property ((wr && pwdata[4]) |-> ##2 resume_drive)
    else $error("resume not driven");
  a_idle_flag_time: assert property ($rose(suspend_event) |-> idle >= ILO && idle <= IHI)
    else $error("idle flag at wrong time");
  a_force_suspend: assert property ((wr && pwdata[3]) |-> ##2 suspended)
    else $error("suspend not entered");
  cover property (usb_irq);
  cover property ($rose(suspend_event));
  cover property ($fell(sleep_wakeup_drive));
endmodule // usbm_sva
bind usbm_ctrl usbm_sva #(.IDLE_CYCLES(IDLE_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_sva (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .bus_reset_event(bus_reset_event),
  .frame_start_event(frame_start_event),
  .expected_frame_start_event(expected_frame_start_event),
  .sleep_request_event(sleep_request_event), .bus_activity(bus_activity),
  .usb_irq(usb_irq), .suspend_event(suspend_event), .resume_drive(resume_drive),
  .sleep_wakeup_drive(sleep_wakeup_drive), .suspended(suspended));

//--- dv/usbm_host_model.sv
// host model: bus traffic and resume completion
module usbm_host_model (
  input wire logic ref_clk,
  input wire logic traffic_on,
  input wire logic resume_drive,
  output logic bus_activity,
  output logic bus_resume_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tog = 1'h0;
  logic rd_q = 1'h0;
  int hold = 0;
  always_ff @(posedge ref_clk) begin
    tog <= !tog;
    rd_q <= resume_drive;
    if (rd_q && !resume_drive) hold <= 4;
    else if (hold > 0) hold <= hold - 1;
  end
  assign bus_resume_seen = hold > 0;
  assign bus_activity = traffic_on && tog;
endmodule // usbm_host_model

//--- dv/tb_top.sv
// testbench: apb sequences against the usb mask and suspend block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IDLE = 50;
  localparam int WAKE = 8;
  localparam logic [7:0] CT = usbm_pkg::CTRL_OFF;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic traffic_on = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ev = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, usb_irq, block_irq, suspend_event, resume_drive;
  logic sleep_wakeup_drive, suspended, low_power, bus_activity, bus_resume_seen;
  int num_errors = 0;
  int tests_run = 0;
  always #2.5 ref_clk = ~ref_clk;
  usbm_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_reset_event(ev[3]),
    .frame_start_event(ev[2]), .expected_frame_start_event(ev[1]),
    .sleep_request_event(ev[0]), .bus_activity(bus_activity),
    .bus_resume_seen(bus_resume_seen), .usb_irq(usb_irq), .block_irq(block_irq),
    .suspend_event(suspend_event), .resume_drive(resume_drive),
    .sleep_wakeup_drive(sleep_wakeup_drive), .suspended(suspended), .low_power(low_power));
  usbm_host_model host (.ref_clk(ref_clk), .traffic_on(traffic_on),
    .resume_drive(resume_drive), .bus_activity(bus_activity),
    .bus_resume_seen(bus_resume_seen));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    apb(1'h0, CT, 32'h0);
    chk("ctrl", rd, usbm_pkg::CTRL_RESET);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      ev <= 4'h1 << i;
      cyc(3);
      chk("masked irq", {31'h0, usb_irq}, 32'h0);
      apb(1'h1, CT, 32'h1 << (7 + i));
      cyc(2);
      chk("irq", {31'h0, usb_irq}, 32'h1);
      @(posedge ref_clk);
      ev <= 4'h0;
      cyc(3);
      chk("irq off", {31'h0, usb_irq}, 32'h0);
    end
    $display("test masks done");
    @(posedge ref_clk);
    traffic_on <= 1'h0;
    cyc(IDLE - 2);
    chk("early idle", {31'h0, suspend_event}, 32'h0);
    cyc(10);
    chk("idle", {31'h0, suspend_event}, 32'h1);
    apb(1'h1, usbm_pkg::IRQ_MASK_OFF, 32'h3);
    cyc(1);
    chk("block irq", {31'h0, block_irq}, 32'h1);
    apb(1'h0, usbm_pkg::IRQ_STAT_OFF, 32'h0);
    chk("stat", rd, 32'h1);
    apb(1'h1, CT, 32'h8);
    apb(1'h1, CT, 32'hc);
    cyc(2);
    chk("suspend lp", {30'h0, suspended, low_power}, 32'h3);
    apb(1'h0, usbm_pkg::STATUS_OFF, 32'h0);
    chk("status", rd, 32'h9);
    apb(1'h1, CT, 32'h0);
    cyc(2);
    chk("write 0", {31'h0, suspended}, 32'h1);
    $display("test suspend done");
    apb(1'h1, CT, 32'h10);
    cyc(2);
    chk("resume", {31'h0, resume_drive}, 32'h1);
    @(posedge ref_clk);
    traffic_on <= 1'h1;
    cyc(20);
    chk("resume held", {31'h0, resume_drive}, 32'h1);
    apb(1'h1, CT, 32'h0);
    cyc(8);
    chk("resumed", {30'h0, resume_drive, suspended}, 32'h0);
    apb(1'h0, usbm_pkg::IRQ_STAT_OFF, 32'h0);
    chk("stat", rd, 32'h2);
    apb(1'h1, CT, 32'h20);
    cyc(2);
    chk("wakeup", {31'h0, sleep_wakeup_drive}, 32'h1);
    cyc(WAKE + 3);
    chk("wakeup end", {31'h0, sleep_wakeup_drive}, 32'h0);
    apb(1'h0, CT, 32'h0);
    chk("bit5 clear", rd & 32'h20, 32'h0);
    chk("done irq", {31'h0, block_irq}, 32'h1);
    $display("test resume done");
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    report_and_stop;
  end
endmodule // tb_top
